/* File: verilog/fprs_pkg.sv */
/*
 * Constants and types for the floating-point register stack and status word.
 * Assumes one processor clock and a single-operation command port from the pipeline.
 */
package fprs_pkg;

    // Status word field positions
    localparam int EXC_LSB = 0;
    localparam int EXC_MSB = 5;
    localparam int INVALID_BIT = 0;
    localparam int INEXACT_BIT = 5;
    localparam int SF_BIT = 6;
    localparam int ES_BIT = 7;
    localparam int CC0_BIT = 8;
    localparam int CC1_BIT = 9;
    localparam int CC2_BIT = 10;
    localparam int TOP_LSB = 11;
    localparam int TOP_MSB = 13;
    localparam int CC3_BIT = 14;
    localparam int BUSY_BIT = 15;

    // Values after reset or reinitialise
    localparam logic [2:0] TOP_RESET = 3'h0;
    localparam logic [3:0] CC_RESET = 4'h0;
    localparam logic [5:0] EXC_RESET = 6'h00;

    // Exponent constants of the formats
    localparam logic [14:0] EXT_EXP_MAX = 15'h7FFF;
    localparam logic [14:0] EXT_BIAS = 15'h3FFF;
    localparam logic [14:0] DBL_TO_EXT = 15'h3C00;
    localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;
    localparam logic [14:0] TRIG_LIMIT_EXP = 15'h403E;
    localparam logic [14:0] INT_MAX_EXP = 15'h401D;
    localparam logic [31:0] INT_INDEFINITE = 32'h8000_0000;

    // Commands taken from the pipeline
    typedef enum logic [3:0] {
        FPRS_NOP = 4'h0,
        FPRS_PUSH_LOAD = 4'h1,
        FPRS_LOAD_SLOT = 4'h2,
        FPRS_POP_STORE = 4'h3,
        FPRS_STORE_SLOT = 4'h4,
        FPRS_SWAP = 4'h5,
        FPRS_ARITH = 4'h6,
        FPRS_COMPARE = 4'h7,
        FPRS_CLASSIFY = 4'h8,
        FPRS_REMAINDER = 4'h9,
        FPRS_TRIG = 4'hA,
        FPRS_SAVE_STATUS = 4'hB,
        FPRS_CLEAR_EXC = 4'hC,
        FPRS_INIT = 4'hD,
        FPRS_RESTORE = 4'hE,
        FPRS_SAVE_STATE = 4'hF
    } fprs_op_t;

    // Memory data formats
    typedef enum logic [1:0] {
        FPRS_FMT_EXT = 2'h0,
        FPRS_FMT_DBL = 2'h1,
        FPRS_FMT_INT = 2'h2,
        FPRS_FMT_RSV = 2'h3
    } fprs_fmt_t;

    // Compare outcomes
    typedef enum logic [1:0] {
        FPRS_CMP_GT = 2'h0,
        FPRS_CMP_LT = 2'h1,
        FPRS_CMP_EQ = 2'h2,
        FPRS_CMP_UN = 2'h3
    } fprs_cmp_t;

endpackage

/* File: verilog/fprs_stack.sv */
/*
 * Eight-entry extended-precision register stack with its status word.
 * Assumes the pipeline issues at most one command per cycle and does the arithmetic itself.
 */
`timescale 1ns/100ps

module fprs_stack import fprs_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Command port
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] op_slot,
    input wire logic [1:0] op_fmt,
    input wire logic [79:0] op_data,
    input wire logic [5:0] op_exc,
    input wire logic op_roundup,
    input wire logic [1:0] op_cmp,
    input wire logic [2:0] op_quot,
    input wire logic op_incomplete,
    input wire logic op_to_ax,
    // Store data to memory
    output logic [79:0] store_data,
    output logic store_valid,
    // Status word copy out
    output logic [15:0] save_word,
    output logic save_valid,
    output logic save_to_ax,
    // Live status word
    output logic [15:0] fp_status_word
);

    // All state of the block except the reset release chain
    typedef struct packed {
        logic [7:0][79:0] regs; // Physical data registers
        logic [7:0] full; // Occupancy, for over and underflow
        logic [2:0] top; // Head index
        logic [3:0] cc; // Condition bits 3..0
        logic [5:0] exc; // Sticky exception flags
        logic sf; // Sticky stack fault
        logic [79:0] st_data;
        logic st_valid;
        logic [15:0] sv_word;
        logic sv_valid;
        logic sv_ax;
        logic [15:0] status;
    } fprs_state_t;

    fprs_state_t s_q; // Registered state
    fprs_state_t s_d; // Next state
    logic [1:0] rst_sync_q; // Reset release chain
    logic rst_n; // Synchronised reset

    // Release reset through two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Memory value into extended format
    function automatic logic [79:0] to_ext(input logic [1:0] fmt, input logic [79:0] v);
        logic [31:0] mag;
        logic [14:0] msb;
        logic [63:0] mant;
        to_ext = v;
        mag = 32'h0;
        msb = 15'h0;
        mant = 64'h0;
        unique case (fmt)
            FPRS_FMT_DBL: begin
                // Denormals flush to zero; no rounding needed upward in width
                if (v[62:52] == 11'h000) begin
                    to_ext = {v[63], 79'h0};
                end else if (v[62:52] == DBL_EXP_MAX) begin
                    to_ext = {v[63], EXT_EXP_MAX, 1'b1, v[51:0], 11'h000};
                end else begin
                    to_ext = {v[63], 15'({4'h0, v[62:52]}) + DBL_TO_EXT, 1'b1, v[51:0], 11'h000};
                end
            end
            FPRS_FMT_INT: begin
                mag = v[31] ? 32'(-v[31:0]) : v[31:0];
                for (int i = 0; i < 32; i++) begin
                    if (mag[i]) begin
                        msb = 15'(i);
                    end
                end
                mant = 64'({mag, 32'h0}) << (6'd31 - 6'(msb));
                if (mag == 32'h0) begin
                    to_ext = 80'h0;
                end else begin
                    to_ext = {v[31], EXT_BIAS + msb, mant};
                end
            end
            default: begin
                to_ext = v; // Already extended
            end
        endcase
    endfunction

    // Extended value out to a memory format
    function automatic logic [79:0] from_ext(input logic [1:0] fmt, input logic [79:0] v);
        logic [14:0] e;
        logic [63:0] mag;
        logic [31:0] ival;
        e = v[78:64];
        mag = 64'h0;
        ival = 32'h0;
        from_ext = v;
        unique case (fmt)
            FPRS_FMT_DBL: begin
                // Truncates the low mantissa bits; range ends clamp
                if (e == EXT_EXP_MAX) begin
                    from_ext = {16'h0, v[79], DBL_EXP_MAX, v[62:11]};
                end else if (e <= DBL_TO_EXT) begin
                    from_ext = {16'h0, v[79], 63'h0};
                end else if (e >= DBL_TO_EXT + 15'({4'h0, DBL_EXP_MAX})) begin
                    from_ext = {16'h0, v[79], DBL_EXP_MAX, 52'h0};
                end else begin
                    from_ext = {16'h0, v[79], 11'(e - DBL_TO_EXT), v[62:11]};
                end
            end
            FPRS_FMT_INT: begin
                // Truncates toward zero; out of range gives the indefinite
                if (e < EXT_BIAS) begin
                    ival = 32'h0;
                end else if (e > INT_MAX_EXP) begin
                    ival = INT_INDEFINITE;
                end else begin
                    mag = v[63:0] >> (6'd63 - 6'(e - EXT_BIAS));
                    ival = v[79] ? 32'(-mag[31:0]) : mag[31:0];
                end
                from_ext = {48'h0, ival};
            end
            default: begin
                from_ext = v; // Kept extended
            end
        endcase
    endfunction

    // Next-state logic for one command
    always_comb begin
        logic [2:0] phys; // Relative slot to physical
        logic [2:0] up; // Head after a push
        logic [79:0] head; // Current head value
        logic [79:0] tmp;
        logic [14:0] hexp;
        logic ovf;
        logic unf;
        phys = 3'(s_q.top + op_slot);
        up = 3'(s_q.top - 3'h1); // 0 wraps to 7
        head = s_q.regs[s_q.top];
        hexp = head[78:64];
        tmp = 80'h0;
        ovf = 1'b0;
        unf = 1'b0;
        s_d = s_q; // Holds across call and return
        s_d.st_valid = 1'b0;
        s_d.sv_valid = 1'b0;
        if (op_valid) begin
            // Exception flags accumulate, except where clear, reinitialise, save-state or restore overwrite them below
            s_d.exc = s_q.exc | op_exc;
            unique case (fprs_op_t'(op_code))
                FPRS_PUSH_LOAD: begin
                    // Decrement first, then write
                    ovf = s_q.full[up];
                    s_d.top = up;
                    s_d.regs[up] = to_ext(op_fmt, op_data);
                    s_d.full[up] = 1'b1;
                    s_d.cc[1] = 1'b0;
                end
                FPRS_LOAD_SLOT: begin
                    // Head unchanged
                    s_d.regs[phys] = to_ext(op_fmt, op_data);
                    s_d.full[phys] = 1'b1;
                    s_d.cc[1] = 1'b0;
                end
                FPRS_POP_STORE: begin
                    // Store head, then increment
                    unf = !s_q.full[s_q.top];
                    s_d.st_data = from_ext(op_fmt, head);
                    s_d.st_valid = 1'b1;
                    s_d.full[s_q.top] = 1'b0;
                    s_d.top = 3'(s_q.top + 3'h1);
                    s_d.cc[1] = op_roundup & op_exc[INEXACT_BIT];
                end
                FPRS_STORE_SLOT: begin
                    // Head unchanged
                    unf = !s_q.full[phys];
                    s_d.st_data = from_ext(op_fmt, s_q.regs[phys]);
                    s_d.st_valid = 1'b1;
                    s_d.cc[1] = op_roundup & op_exc[INEXACT_BIT];
                end
                FPRS_SWAP: begin
                    // Exchange head with a relative slot
                    unf = !s_q.full[s_q.top] || !s_q.full[phys];
                    s_d.regs[s_q.top] = s_q.regs[phys];
                    s_d.regs[phys] = head;
                    s_d.cc[1] = 1'b0;
                end
                FPRS_ARITH: begin
                    // Result from the datapath; bit one is round-up
                    unf = !s_q.full[phys];
                    s_d.regs[phys] = op_data;
                    s_d.full[phys] = 1'b1;
                    s_d.cc[1] = op_roundup & op_exc[INEXACT_BIT];
                end
                FPRS_COMPARE: begin
                    // Bits 3,2,0 give order
                    unf = !s_q.full[s_q.top];
                    s_d.cc[1] = 1'b0;
                    unique case (fprs_cmp_t'(op_cmp))
                        FPRS_CMP_GT: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h0;
                        FPRS_CMP_LT: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h1;
                        FPRS_CMP_EQ: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h4;
                        FPRS_CMP_UN: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h7;
                    endcase
                end
                FPRS_CLASSIFY: begin
                    // Sign into bit one, class into 3,2,0
                    s_d.cc[1] = head[79];
                    if (!s_q.full[s_q.top]) begin
                        {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h5; // Empty
                    end else if (hexp == EXT_EXP_MAX) begin
                        // Infinity when bits 62..0 are zero, whatever the integer bit
                        {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = (head[62:0] == 63'h0) ? 3'h3 : 3'h1;
                    end else if (hexp == 15'h0) begin
                        {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = (head[63:0] == 64'h0) ? 3'h4 : 3'h6;
                    end else if (!head[63]) begin
                        {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h0; // Unsupported
                    end else begin
                        {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'h2; // Normal
                    end
                end
                FPRS_REMAINDER: begin
                    // Bit two flags incomplete
                    unf = !s_q.full[s_q.top];
                    s_d.cc[2] = op_incomplete;
                    s_d.regs[s_q.top] = op_data;
                    if (!op_incomplete) begin
                        // Quotient bits 2,1,0 to cc 0,3,1
                        s_d.cc[0] = op_quot[2];
                        s_d.cc[3] = op_quot[1];
                        s_d.cc[1] = op_quot[0];
                    end
                end
                FPRS_TRIG: begin
                    // Finite operands at or beyond 2^63 leave the operand in place
                    unf = !s_q.full[s_q.top];
                    if (hexp >= TRIG_LIMIT_EXP && hexp != EXT_EXP_MAX) begin
                        s_d.cc[2] = 1'b1;
                    end else begin
                        s_d.cc[2] = 1'b0;
                        s_d.regs[s_q.top] = op_data;
                        s_d.cc[1] = op_roundup & op_exc[INEXACT_BIT];
                    end
                end
                FPRS_SAVE_STATUS: begin
                    // Copy to memory or AX
                    s_d.sv_word = s_q.status;
                    s_d.sv_valid = 1'b1;
                    s_d.sv_ax = op_to_ax;
                end
                FPRS_CLEAR_EXC: begin
                    // Explicit clear of sticky bits
                    s_d.exc = EXC_RESET;
                    s_d.sf = 1'b0;
                end
                FPRS_INIT, FPRS_SAVE_STATE: begin
                    // Save-state outputs the word, then reinitialises
                    s_d.sv_word = s_q.status;
                    s_d.sv_valid = (fprs_op_t'(op_code) == FPRS_SAVE_STATE);
                    s_d.sv_ax = 1'b0;
                    s_d.exc = EXC_RESET;
                    s_d.sf = 1'b0;
                    s_d.cc = CC_RESET;
                    s_d.top = TOP_RESET;
                    s_d.full = 8'h00;
                end
                FPRS_RESTORE: begin
                    // Environment restore overwrites the word
                    s_d.exc = op_data[EXC_MSB:EXC_LSB];
                    s_d.sf = op_data[SF_BIT];
                    s_d.cc = {op_data[CC3_BIT], op_data[CC2_BIT], op_data[CC1_BIT], op_data[CC0_BIT]};
                    s_d.top = op_data[TOP_MSB:TOP_LSB];
                end
                default: begin
                    // No operation
                end
            endcase
            if (ovf || unf) begin
                // Fault sets flags; bit one tells the kind
                s_d.sf = 1'b1;
                s_d.exc[INVALID_BIT] = 1'b1;
                s_d.cc[1] = ovf;
            end
        end
        // Assemble the word from next state
        s_d.status = 16'h0000;
        s_d.status[EXC_MSB:EXC_LSB] = s_d.exc;
        s_d.status[SF_BIT] = s_d.sf;
        s_d.status[CC0_BIT] = s_d.cc[0];
        s_d.status[CC1_BIT] = s_d.cc[1];
        s_d.status[CC2_BIT] = s_d.cc[2];
        s_d.status[TOP_MSB:TOP_LSB] = s_d.top;
        s_d.status[CC3_BIT] = s_d.cc[3];
        // Summary and busy need the control word; read zero here
        s_d.status[ES_BIT] = 1'b0;
        s_d.status[BUSY_BIT] = 1'b0;
    end

    // Register the whole state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign store_data = s_q.st_data;
    assign store_valid = s_q.st_valid;
    assign save_word = s_q.sv_word;
    assign save_valid = s_q.sv_valid;
    assign save_to_ax = s_q.sv_ax;
    assign fp_status_word = s_q.status;

endmodule // fprs_stack

/* File: dv/fprs_stack_sva.sv */
/* Checker for the register stack and its status word.
   Sees only the top ports; bound to fprs_stack after the module. */
`timescale 1ns/100ps

module fprs_stack_chk import fprs_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Command port
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] op_slot,
    input wire logic [1:0] op_fmt,
    input wire logic [79:0] op_data,
    input wire logic [5:0] op_exc,
    input wire logic op_roundup,
    input wire logic [1:0] op_cmp,
    input wire logic [2:0] op_quot,
    input wire logic op_incomplete,
    input wire logic op_to_ax,
    // Outputs watched
    input wire logic [79:0] store_data,
    input wire logic store_valid,
    input wire logic [15:0] save_word,
    input wire logic save_valid,
    input wire logic save_to_ax,
    input wire logic [15:0] fp_status_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Head index field of the live word
    wire logic [2:0] top = fp_status_word[13:11];
    // Exponent of the incoming operand
    wire logic [14:0] src_exp = op_data[78:64];
    // Incoming operand at or beyond the trig range limit
    wire logic src_far = src_exp >= TRIG_LIMIT_EXP && src_exp != EXT_EXP_MAX;
    // Raw load of the head; the trig source is the head, not the port
    wire logic head_load = op_valid && op_code == FPRS_LOAD_SLOT && op_slot == 3'h0 && op_fmt == FPRS_FMT_EXT;
    // Store commands
    wire logic is_store = op_valid && (op_code == FPRS_POP_STORE || op_code == FPRS_STORE_SLOT);

    // A command of the given code is taken
    sequence s_take(logic [3:0] c);
        op_valid && op_code == c;
    endsequence
    // A completed remainder reduction is taken
    sequence s_rem_done;
        s_take(FPRS_REMAINDER) ##0 !op_incomplete;
    endsequence
    // Head loaded raw, one idle cycle, then a trig command on it
    sequence s_trig_after(logic far);
        head_load && src_far == far ##1 !op_valid ##1 s_take(FPRS_TRIG);
    endsequence

    chk_push_top_down: assert property (s_take(FPRS_PUSH_LOAD) |=>
        top == $past(top) - 3'h1)
        else $error("push did not step head down by one");
    chk_pop_top_up: assert property (s_take(FPRS_POP_STORE) |=> top == $past(top) + 3'h1)
        else $error("pop did not step head up by one");
    chk_store_pulse: assert property (is_store |=> store_valid)
        else $error("store command gave no store pulse");
    chk_save_copy: assert property (s_take(FPRS_SAVE_STATUS) |=> save_valid
        && save_word == $past(fp_status_word) && save_to_ax == $past(op_to_ax))
        else $error("status copy wrong");
    chk_flags_sticky: assert property (!(op_valid && op_code inside {FPRS_CLEAR_EXC, FPRS_INIT,
        FPRS_RESTORE, FPRS_SAVE_STATE}) |=> (fp_status_word[6:0] & $past(fp_status_word[6:0]))
        == $past(fp_status_word[6:0]))
        else $error("sticky flag dropped");
    chk_flags_raise: assert property (s_take(FPRS_ARITH) |=>
        (fp_status_word[5:0] & $past(op_exc)) == $past(op_exc))
        else $error("raised flag not recorded");
    chk_trig_out: assert property (s_trig_after(1'b1) |=> fp_status_word[CC2_BIT])
        else $error("out of range source not flagged");
    chk_trig_in: assert property (s_trig_after(1'b0) |=> !fp_status_word[CC2_BIT])
        else $error("in range source flagged");
    chk_rem_quot: assert property (s_rem_done |=> {fp_status_word[8], fp_status_word[14],
        fp_status_word[9], fp_status_word[10]} == {$past(op_quot), 1'b0})
        else $error("quotient bits not in condition bits");
    chk_init_zero: assert property (s_take(FPRS_INIT) |=> fp_status_word == 16'h0000)
        else $error("reinitialise left status set");
    chk_idle_hold: assert property (!op_valid |=> $stable(fp_status_word)
        && !store_valid && !save_valid)
        else $error("idle cycle changed state");
endmodule // fprs_stack_chk

bind fprs_stack fprs_stack_chk i_chk (.sys_clk(sys_clk), .resetn(resetn), .op_valid(op_valid),
    .op_code(op_code), .op_slot(op_slot), .op_fmt(op_fmt), .op_data(op_data), .op_exc(op_exc),
    .op_roundup(op_roundup), .op_cmp(op_cmp), .op_quot(op_quot), .op_incomplete(op_incomplete),
    .op_to_ax(op_to_ax), .store_data(store_data), .store_valid(store_valid), .save_word(save_word),
    .save_valid(save_valid), .save_to_ax(save_to_ax), .fp_status_word(fp_status_word));

/* File: dv/fprs_mem_model.sv */
/* Memory and integer-unit side of the stack: keeps the last stored value
   and the status copy sent to the AX register. Sits on the stack outputs. */
`timescale 1ns/100ps

module fprs_mem_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Stack outputs
    input wire logic [79:0] store_data,
    input wire logic store_valid,
    input wire logic [15:0] save_word,
    input wire logic save_valid,
    input wire logic save_to_ax,
    // Captured copies
    output logic [79:0] mem_q,
    output logic [15:0] ax_q
);
    // Capture on the pulse only, since data is stale otherwise
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mem_q <= 80'h0;
            ax_q <= 16'h0000;
        end else begin
            if (store_valid) begin
                mem_q <= store_data;
            end
            if (save_valid && save_to_ax) begin
                ax_q <= save_word;
            end
        end
    end
    // No packed-integer code runs here, so stack values are never clobbered
    // Condition bits are never consumed, so undefined ones cannot mislead
endmodule // fprs_mem_model

/* File: dv/tb_top.sv */
/* Self-checking bench for the register stack: issues commands, checks
   stores, status copies and the live word. Needs the stack and memory model. */
`timescale 1ns/100ps

module tb_top import fprs_pkg::*; ;
    // Clock, reset and command drive
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic op_valid = 1'b0;
    logic [3:0] op_code = 4'h0;
    logic [2:0] op_slot = 3'h0;
    logic [1:0] op_fmt = 2'h0;
    logic [79:0] op_data = 80'h0;
    logic [5:0] op_exc = 6'h00;
    logic op_roundup = 1'b0;
    logic [1:0] op_cmp = 2'h0;
    logic [2:0] op_quot = 3'h0;
    logic op_incomplete = 1'b0;
    logic op_to_ax = 1'b0;
    // Outputs of design and model
    logic [79:0] store_data;
    logic store_valid;
    logic [15:0] save_word;
    logic save_valid;
    logic save_to_ax;
    logic [15:0] fp_status_word;
    logic [79:0] mem_q;
    logic [15:0] ax_q;
    int num_errors = 0;
    int checks_done = 0;
    // Five, one and minus one in extended format
    localparam logic [79:0] EXT_FIVE = 80'h4001_A000_0000_0000_0000;
    localparam logic [79:0] EXT_ONE = 80'h3FFF_8000_0000_0000_0000;
    localparam logic [79:0] EXT_MONE = 80'hBFFF_8000_0000_0000_0000;
    // Two to the 63, the first magnitude out of trig range
    localparam logic [79:0] EXT_FAR = 80'h403E_8000_0000_0000_0000;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    fprs_stack i_fprs_stack (.sys_clk(sys_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
        .op_slot(op_slot), .op_fmt(op_fmt), .op_data(op_data), .op_exc(op_exc), .op_roundup(op_roundup),
        .op_cmp(op_cmp), .op_quot(op_quot), .op_incomplete(op_incomplete), .op_to_ax(op_to_ax),
        .store_data(store_data), .store_valid(store_valid), .save_word(save_word), .save_valid(save_valid),
        .save_to_ax(save_to_ax), .fp_status_word(fp_status_word));
    fprs_mem_model i_fprs_mem_model (.sys_clk(sys_clk), .resetn(resetn), .store_data(store_data),
        .store_valid(store_valid), .save_word(save_word), .save_valid(save_valid), .save_to_ax(save_to_ax),
        .mem_q(mem_q), .ax_q(ax_q));

    // One command, taken at one edge; outputs read just after it
    task automatic run(input logic [3:0] c, input logic [2:0] s, input logic [1:0] f, input logic [79:0] d);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_slot <= s;
        op_fmt <= f;
        op_data <= d;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
    endtask
    // Store value, unknown if the pulse is missing
    function automatic logic [79:0] stored();
        return (store_valid === 1'b1) ? store_data : 'x;
    endfunction
    // Compare a status-width value
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare a data-width value
    task automatic chk80(input string what, input logic [79:0] exp, input logic [79:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog, well past the roughly 80 cycles the tests need
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk16("status", 16'h0000, fp_status_word);
        run(FPRS_PUSH_LOAD, 3'h0, FPRS_FMT_INT, 80'h5);
        chk16("status", 16'h3800, fp_status_word);
        run(FPRS_PUSH_LOAD, 3'h0, FPRS_FMT_INT, 80'h9);
        chk16("status", 16'h3000, fp_status_word);
        run(FPRS_STORE_SLOT, 3'h1, FPRS_FMT_EXT, 80'h0);
        chk80("store", EXT_FIVE, stored());
        chk16("status", 16'h3000, fp_status_word);
        run(FPRS_LOAD_SLOT, 3'h1, FPRS_FMT_INT, 80'h7);
        run(FPRS_STORE_SLOT, 3'h1, FPRS_FMT_INT, 80'h0);
        chk80("store", 80'h7, stored());
        run(FPRS_PUSH_LOAD, 3'h0, FPRS_FMT_DBL, 80'h3FF0_0000_0000_0000);
        run(FPRS_STORE_SLOT, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk80("store", EXT_ONE, stored());
        run(FPRS_STORE_SLOT, 3'h0, FPRS_FMT_DBL, 80'h0);
        chk80("store", 80'h3FF0_0000_0000_0000, stored());
        run(FPRS_POP_STORE, 3'h0, FPRS_FMT_INT, 80'h0);
        chk80("store", 80'h1, stored());
        run(FPRS_NOP, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("status", 16'h3000, fp_status_word);
        run(FPRS_POP_STORE, 3'h0, FPRS_FMT_INT, 80'h0);
        chk80("store", 80'h9, stored());
        // The model captures on the edge after the pulse
        @(posedge sys_clk);
        #1;
        chk80("memory", 80'h9, mem_q);
        op_to_ax <= 1'b1;
        run(FPRS_SAVE_STATUS, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("save", 16'h3800, (save_valid === 1'b1) ? save_word : 16'hXXXX);
        @(posedge sys_clk);
        #1;
        chk16("ax", 16'h3800, ax_q);
        op_exc <= 6'h20;
        op_roundup <= 1'b1;
        run(FPRS_ARITH, 3'h0, FPRS_FMT_EXT, EXT_FIVE);
        chk16("status", 16'h3A20, fp_status_word);
        op_exc <= 6'h00;
        op_roundup <= 1'b0;
        run(FPRS_CLEAR_EXC, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("flags", 16'h0000, fp_status_word & 16'h007F);
        op_quot <= 3'h5;
        run(FPRS_REMAINDER, 3'h0, FPRS_FMT_EXT, EXT_FIVE);
        chk16("status", 16'h3B00, fp_status_word);
        op_incomplete <= 1'b1;
        run(FPRS_REMAINDER, 3'h0, FPRS_FMT_EXT, EXT_FIVE);
        chk16("cond two", 16'h0400, fp_status_word & 16'h0400);
        op_incomplete <= 1'b0;
        // The trig source is the head, so load it first
        run(FPRS_LOAD_SLOT, 3'h0, FPRS_FMT_EXT, EXT_ONE);
        run(FPRS_TRIG, 3'h0, FPRS_FMT_EXT, EXT_ONE);
        chk16("cond two", 16'h0000, fp_status_word & 16'h0400);
        run(FPRS_LOAD_SLOT, 3'h0, FPRS_FMT_EXT, EXT_FAR);
        run(FPRS_TRIG, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("cond two", 16'h0400, fp_status_word & 16'h0400);
        run(FPRS_PUSH_LOAD, 3'h0, FPRS_FMT_EXT, EXT_MONE);
        run(FPRS_CLASSIFY, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("status", 16'h3600, fp_status_word);
        // Swap brings the untouched out-of-range operand to the head
        run(FPRS_SWAP, 3'h1, FPRS_FMT_EXT, 80'h0);
        run(FPRS_STORE_SLOT, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk80("store", EXT_FAR, stored());
        op_cmp <= FPRS_CMP_EQ;
        run(FPRS_COMPARE, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("status", 16'h7000, fp_status_word);
        // Slot three maps to an empty register here
        run(FPRS_STORE_SLOT, 3'h3, FPRS_FMT_INT, 80'h0);
        chk16("fault", 16'h0041, fp_status_word & 16'h0241);
        run(FPRS_RESTORE, 3'h0, FPRS_FMT_EXT, 80'h6C41);
        chk16("status", 16'h6C41, fp_status_word);
        op_to_ax <= 1'b0;
        run(FPRS_SAVE_STATE, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("save", 16'h6C41, (save_valid === 1'b1) ? save_word : 16'hXXXX);
        chk16("status", 16'h0000, fp_status_word);
        run(FPRS_RESTORE, 3'h0, FPRS_FMT_EXT, 80'h6C41);
        run(FPRS_INIT, 3'h0, FPRS_FMT_EXT, 80'h0);
        chk16("status", 16'h0000, fp_status_word);
        report_and_stop();
    end
endmodule // tb_top
